/* btg_pkg.sv */
// Package: register map, field layout, reset values and timing for the buzzer tone generator
package btg_pkg;

    // Register indices as printed; the APB byte address is four times the index
    localparam logic [17:0] BTG_CTL_IDX = 18'h05180;
    localparam logic [17:0] BTG_FREQ_IDX = 18'h05181;
    localparam logic [17:0] BTG_DUTY_IDX = 18'h05182;
    localparam int BTG_ADDR_W = 20;
    localparam logic [19:0] BTG_CTL_ADDR = {BTG_CTL_IDX, 2'b00};
    localparam logic [19:0] BTG_FREQ_ADDR = {BTG_FREQ_IDX, 2'b00};
    localparam logic [19:0] BTG_DUTY_ADDR = {BTG_DUTY_IDX, 2'b00};

    // tone_control field positions
    localparam int BTG_EN_BIT = 0;
    localparam int BTG_MODE_LSB = 2;
    localparam int BTG_TIME_LSB = 4;

    // Reset values
    localparam logic [1:0] BTG_TIME_RST = 2'h0;
    localparam logic [1:0] BTG_MODE_RST = 2'h0;
    localparam logic [2:0] BTG_FREQ_RST = 3'h0;
    localparam logic [2:0] BTG_DUTY_RST = 3'h0;

    // Mode codes; code 3 is reserved and behaves as normal
    localparam logic [1:0] BTG_MODE_NORMAL = 2'h0;
    localparam logic [1:0] BTG_MODE_ONESHOT = 2'h1;
    localparam logic [1:0] BTG_MODE_ENVELOPE = 2'h2;

    // Envelope walks levels 1..7; codes 0..6, stop when the last one expires
    localparam logic [2:0] BTG_LEVEL_MAX = 3'h0;
    localparam logic [2:0] BTG_LEVEL_MIN = 3'h7;

    // Interval durations in microseconds
    localparam longint BTG_T0_US = 15630;
    localparam longint BTG_T1_US = 31250;
    localparam longint BTG_T2_US = 62500;
    localparam longint BTG_T3_US = 125000;
    localparam longint BTG_US_PER_S = 1000000;

    // Nominal sound clock rate: one tone tick per rising edge
    localparam int BTG_SND_HZ = 65536;

    // Tone period in ticks per frequency pair, and high time at level 1
    localparam logic [4:0] BTG_PER_P0 = 5'h10;
    localparam logic [4:0] BTG_PER_P1 = 5'h14;
    localparam logic [4:0] BTG_PER_P2 = 5'h18;
    localparam logic [4:0] BTG_PER_P3 = 5'h1C;
    localparam logic [4:0] BTG_HIGH_SHORT = 5'h08;
    localparam logic [4:0] BTG_HIGH_LONG = 5'h0C;

endpackage

/* btg_tone_if.sv */
// Interface: control path between the register/sequencer core and the waveform generator
interface btg_tone_if;
    logic tick;
    logic run;
    logic [2:0] freq;
    logic [2:0] duty;
    logic tone;

    modport ctl (output tick, output run, output freq, output duty, input tone);
    modport gen (input tick, input run, input freq, input duty, output tone);
endinterface

/* btg_wave.sv */
// Module: square tone waveform generator clocked by sound-clock ticks
module btg_wave
    import btg_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control from the core
    btg_tone_if.gen tif
);

    typedef struct packed {
        logic half;
        logic [4:0] cnt;
        logic tone;
    } btg_wave_t;

    btg_wave_t s_q;
    btg_wave_t s_d;
    logic [4:0] period;
    logic [4:0] high;

    always_comb begin
        case (tif.freq[1:0])
            2'h0: period = BTG_PER_P0;
            2'h1: period = BTG_PER_P1;
            2'h2: period = BTG_PER_P2;
            default: period = BTG_PER_P3;
        endcase
        high = (tif.freq[1] ? BTG_HIGH_LONG : BTG_HIGH_SHORT) - {2'h0, tif.duty};
    end

    always_comb begin
        s_d = s_q;
        if (!tif.run) begin
            s_d = '0;
        end else if (tif.tick) begin
            // Upper four codes use every second tick, halving the pitch
            s_d.half = tif.freq[2] ? ~s_q.half : 1'b0;
            if (!tif.freq[2] || s_q.half) begin
                s_d.cnt = (s_q.cnt >= period - 5'h01) ? 5'h00 : s_q.cnt + 5'h01;
            end
            // Pin moves only on sound ticks, so a register write never glitches it
            s_d.tone = s_d.cnt < high;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tif.tone = s_q.tone;

endmodule

/* btg_top.sv */
// Module: buzzer tone generator core with APB registers and mode sequencer
//
// Decided for this implementation: the APB register port.
module btg_top
    import btg_pkg::*;
#(
    parameter int sound_clock_config_hz = btg_pkg::BTG_SND_HZ
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [btg_pkg::BTG_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sound clock from the external oscillator divider
    input wire logic sound_clock,
    // Buzzer pin
    output logic tone_out
);

    // Interval lengths in sound-clock ticks, rounded down, never below one
    localparam longint CNT0_L = BTG_T0_US * longint'(sound_clock_config_hz) / BTG_US_PER_S;
    localparam longint CNT1_L = BTG_T1_US * longint'(sound_clock_config_hz) / BTG_US_PER_S;
    localparam longint CNT2_L = BTG_T2_US * longint'(sound_clock_config_hz) / BTG_US_PER_S;
    localparam longint CNT3_L = BTG_T3_US * longint'(sound_clock_config_hz) / BTG_US_PER_S;
    localparam logic [15:0] CNT0 = (CNT0_L < 1) ? 16'h0001 : 16'(CNT0_L);
    localparam logic [15:0] CNT1 = (CNT1_L < 1) ? 16'h0001 : 16'(CNT1_L);
    localparam logic [15:0] CNT2 = (CNT2_L < 1) ? 16'h0001 : 16'(CNT2_L);
    localparam logic [15:0] CNT3 = (CNT3_L < 1) ? 16'h0001 : 16'(CNT3_L);

    typedef enum logic [1:0] {
        BTG_IDLE,
        BTG_RUN
    } btg_state_t;

    typedef struct packed {
        // Sound clock synchroniser and edge history
        logic sc_meta;
        logic sc_sync;
        logic sc_prev;
        // APB answer
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        // Configuration fields
        logic [1:0] time_sel;
        logic [1:0] mode_sel;
        logic [2:0] freq_sel;
        logic [2:0] duty_sel;
        // Control bit write waiting for the next sound tick
        logic pend;
        logic pend_val;
        // Sequencer
        btg_state_t state;
        logic [15:0] timer;
        logic [2:0] level;
    } btg_top_t;

    btg_top_t s_q;
    btg_top_t s_d;

    btg_tone_if tif ();

    logic tick;
    logic hit_ctl;
    logic hit_freq;
    logic hit_duty;
    logic hit_any;
    logic setup;
    logic access;
    logic [15:0] limit;
    logic en_bit;
    logic timed_mode;

    // Sound clock edge detect reads the second stage and its delayed copy, never the first
    assign tick = s_q.sc_sync & ~s_q.sc_prev;

    // Address decode over full word addresses
    assign hit_ctl = (paddr == BTG_CTL_ADDR);
    assign hit_freq = (paddr == BTG_FREQ_ADDR);
    assign hit_duty = (paddr == BTG_DUTY_ADDR);
    assign hit_any = hit_ctl | hit_freq | hit_duty;

    // One wait state: answer raised in the second access cycle, taken on the next edge
    assign setup = psel & penable & ~s_q.pready;
    assign access = psel & penable & s_q.pready;

    // Interval length from the time code
    always_comb begin
        case (s_q.time_sel)
            2'h0: limit = CNT0;
            2'h1: limit = CNT1;
            2'h2: limit = CNT2;
            default: limit = CNT3;
        endcase
    end

    // Only one-shot and envelope are timed; reserved acts as normal
    assign timed_mode = (s_q.mode_sel == BTG_MODE_ONESHOT) ||
                        (s_q.mode_sel == BTG_MODE_ENVELOPE);

    // Control bit reads the running status, not the last write
    assign en_bit = (s_q.state == BTG_RUN);

    // Next-state logic
    always_comb begin
        s_d = s_q;
        s_d.sc_meta = sound_clock;
        s_d.sc_sync = s_q.sc_meta;
        s_d.sc_prev = s_q.sc_sync;

        // APB answer and read data
        s_d.pready = setup;
        s_d.pslverr = setup & ~hit_any;
        if (setup && !pwrite) begin
            s_d.prdata = 32'h00000000;
            if (hit_ctl) begin
                s_d.prdata[BTG_TIME_LSB +: 2] = s_q.time_sel;
                s_d.prdata[BTG_MODE_LSB +: 2] = s_q.mode_sel;
                s_d.prdata[BTG_EN_BIT] = en_bit;
            end else if (hit_freq) begin
                s_d.prdata[2:0] = s_q.freq_sel;
            end else if (hit_duty) begin
                s_d.prdata[2:0] = s_q.duty_sel;
            end
        end

        // Control bit writes wait for the next sound tick
        if (tick && s_q.pend) begin
            s_d.pend = 1'b0;
        end

        // Register writes take effect on the completing edge
        if (access && pwrite) begin
            if (hit_ctl) begin
                s_d.time_sel = pwdata[BTG_TIME_LSB +: 2];
                s_d.mode_sel = pwdata[BTG_MODE_LSB +: 2];
                s_d.pend = 1'b1;
                s_d.pend_val = pwdata[BTG_EN_BIT];
            end
            if (hit_freq) begin
                s_d.freq_sel = pwdata[2:0];
            end
            if (hit_duty) begin
                s_d.duty_sel = pwdata[2:0];
            end
        end

        // Sequencer advances only on sound ticks
        if (tick) begin
            if (s_q.pend && s_q.pend_val) begin
                // Start or restart from the top
                s_d.state = BTG_RUN;
                s_d.timer = 16'h0000;
                s_d.level = BTG_LEVEL_MAX;
            end else if (s_q.pend) begin
                s_d.state = BTG_IDLE;
                s_d.timer = 16'h0000;
                s_d.level = BTG_LEVEL_MAX;
            end else begin
                case (s_q.state)
                    BTG_IDLE: begin
                        s_d.timer = 16'h0000;
                    end
                    BTG_RUN: begin
                        if (timed_mode) begin
                            if (s_q.timer >= limit - 16'h0001) begin
                                s_d.timer = 16'h0000;
                                if (s_q.mode_sel == BTG_MODE_ONESHOT) begin
                                    s_d.state = BTG_IDLE;
                                end else if (s_q.level == BTG_LEVEL_MIN - 3'h1) begin
                                    // Expiry of level 7 ends the envelope
                                    s_d.state = BTG_IDLE;
                                    s_d.level = BTG_LEVEL_MAX;
                                end else begin
                                    s_d.level = s_q.level + 3'h1;
                                end
                            end else begin
                                s_d.timer = s_q.timer + 16'h0001;
                            end
                        end
                    end
                    default: begin
                        s_d.state = BTG_IDLE;
                    end
                endcase
            end
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q.sc_meta <= 1'b0;
            s_q.sc_sync <= 1'b0;
            s_q.sc_prev <= 1'b0;
            s_q.pready <= 1'b0;
            s_q.pslverr <= 1'b0;
            s_q.prdata <= 32'h00000000;
            s_q.time_sel <= BTG_TIME_RST;
            s_q.mode_sel <= BTG_MODE_RST;
            s_q.freq_sel <= BTG_FREQ_RST;
            s_q.duty_sel <= BTG_DUTY_RST;
            s_q.pend <= 1'b0;
            s_q.pend_val <= 1'b0;
            s_q.state <= BTG_IDLE;
            s_q.timer <= 16'h0000;
            s_q.level <= BTG_LEVEL_MAX;
        end else begin
            s_q <= s_d;
        end
    end

    // Waveform generator control
    assign tif.tick = tick;
    assign tif.run = (s_q.state == BTG_RUN);
    assign tif.freq = s_q.freq_sel;
    // Envelope level replaces the programmed duty
    assign tif.duty = (s_q.mode_sel == BTG_MODE_ENVELOPE) ? s_q.level : s_q.duty_sel;

    // Waveform generator; its output is a flip-flop
    btg_wave u_wave (
        .pclk(pclk),
        .presetn(presetn),
        .tif(tif)
    );

    // Outputs straight from flip-flops
    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign tone_out = tif.tone;

endmodule

/* btg_props.sv */
// Checker: bus handshake, reserved-bit and tone timing properties of the tone generator
module btg_props
    import btg_pkg::*;
#(
    parameter int sound_clock_config_hz = 65536
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [btg_pkg::BTG_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Sound clock and buzzer pin
    input wire logic sound_clock,
    input wire logic tone_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sc_q;
    logic [3:0] since_q;
    logic mapped;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Bus cycles since the last raw sound edge; saturates so idle gaps stay quiet
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sc_q <= 1'b0;
            since_q <= 4'hF;
        end else begin
            sc_q <= sound_clock;
            if (sound_clock && !sc_q) begin
                since_q <= 4'h0;
            end else if (since_q != 4'hF) begin
                since_q <= since_q + 4'h1;
            end
        end
    end
    // Decode of the three register words
    assign mapped = paddr == BTG_CTL_ADDR || paddr == BTG_FREQ_ADDR || paddr == BTG_DUTY_ADDR;
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_wait;
        psel && penable && !pready;
    endsequence
    property p_one_wait;
        s_setup |=> s_wait ##1 pready;
    endproperty
    property p_rdy_pulse;
        pready |=> !pready;
    endproperty
    property p_rdy_qual;
        pready |-> psel && penable;
    endproperty
    property p_err_unmapped;
        pready && !mapped |-> pslverr && (pwrite || prdata == 32'h0);
    endproperty
    property p_err_mapped;
        pready && mapped |-> !pslverr;
    endproperty
    property p_rd_upper;
        pready && !pwrite |-> prdata[31:8] == 24'h0;
    endproperty
    property p_rd_rsvd;
        pready && !pwrite && mapped |->
            (paddr == BTG_CTL_ADDR ? prdata[7:6] == 2'h0 && !prdata[1] : prdata[7:3] == 5'h0);
    endproperty
    property p_tone_sync;
        $changed(tone_out) |-> since_q <= 4'h8;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("pready not after one wait state");
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready longer than one cycle");
    a_rdy_qual: assert property (p_rdy_qual) else $error("pready outside an access phase");
    a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not refused");
    a_err_mapped: assert property (p_err_mapped) else $error("mapped access refused");
    a_rd_upper: assert property (p_rd_upper) else $error("upper read bits not zero");
    a_rd_rsvd: assert property (p_rd_rsvd) else $error("reserved read bits not zero");
    a_tone_sync: assert property (p_tone_sync) else $error("tone edge off the sound tick");
endmodule

bind btg_top btg_props #(.sound_clock_config_hz(sound_clock_config_hz)) u_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sound_clock(sound_clock),
    .tone_out(tone_out));

/* btg_buzzer.sv */
// Partner: piezo buzzer that measures high time and period of the tone pin in bus cycles
module btg_buzzer (
    // Bus clock used as time base
    input wire logic pclk,
    // Buzzer pin
    input wire logic tone_out,
    // Last measured pulse, in bus cycles
    output logic [31:0] high_len,
    output logic [31:0] period_len
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] cnt;
    logic prev;
    initial begin
        cnt = 32'h0;
        prev = 1'b0;
        high_len = 32'h0;
        period_len = 32'h0;
    end
    // Rise restarts the count, so a fall gives high time and a rise gives the period
    always @(posedge pclk) begin
        prev <= tone_out;
        cnt <= cnt + 32'h1;
        if (tone_out && !prev) begin
            period_len <= cnt;
            cnt <= 32'h1;
        end
        if (!tone_out && prev) begin
            high_len <= cnt;
        end
    end
endmodule

/* tb.sv */
// Testbench: register, tone pitch, duty, one-shot and envelope checks over APB
module tb;
    import btg_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SND_HZ = 4096;
    localparam int TPC = 16;
    logic pclk, presetn, psel, penable, pwrite, sound_clock, pready, pslverr, tone_out, ee;
    logic [19:0] paddr;
    logic [31:0] pwdata, prdata, high_len, period_len, rr;
    int n_mismatch, total_checks, cyc, tk, t0, n;
    longint us_tab [4];

    btg_top #(.sound_clock_config_hz(SND_HZ)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sound_clock(sound_clock), .tone_out(tone_out));
    btg_buzzer u_buzz (.pclk(pclk), .tone_out(tone_out), .high_len(high_len),
        .period_len(period_len));

    // Bus clock, and a sound clock of 16 bus cycles offset so edges never coincide
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    initial begin
        sound_clock = 1'b0;
        #5;
        forever #32 sound_clock = ~sound_clock;
    end
    always @(posedge sound_clock) tk++;
    // Hang guard well above the expected run length
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 95000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [19:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the bench timeout ends a wait for the answer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [19:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rr, ee);
    endtask
    task automatic rd(input string nm, input logic [19:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, rr, ee);
        chk(nm, rr, exp);
    endtask
    task automatic ticks(input int k);
        repeat (k) @(posedge sound_clock);
    endtask
    // Poll the output-control bit until it clears; a late poll only adds a tick or two
    task automatic run_len(input int start, input int exp, input string nm);
        int k;
        k = 0;
        rr = 32'h1;
        while (rr[0] === 1'b1 && k < 4000) begin
            apb(1'b0, BTG_CTL_ADDR, 32'h0, rr, ee);
            k++;
        end
        chk(nm, {31'h0, (tk - start >= exp - 1 && tk - start <= exp + 3)}, 32'h1);
        // The pin has fallen at least one edge before the read ends; one more edge is margin
        @(posedge pclk);
        chk("tone_idle", {31'h0, tone_out}, 32'h0);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        us_tab = '{BTG_T0_US, BTG_T1_US, BTG_T2_US, BTG_T3_US};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd("ctl_rst", BTG_CTL_ADDR, 32'h0);
        rd("freq_rst", BTG_FREQ_ADDR, 32'h0);
        rd("duty_rst", BTG_DUTY_ADDR, 32'h0);
        apb(1'b0, 20'h14610, 32'h0, rr, ee);
        chk("unmapped_err", {31'h0, ee}, 32'h1);
        chk("unmapped_data", rr, 32'h0);
        // Normal mode across every pitch and duty code; only defined bits written
        wr(BTG_CTL_ADDR, 32'h01);
        for (int f = 0; f < 8; f++) begin
            wr(BTG_FREQ_ADDR, f);
            wr(BTG_DUTY_ADDR, f);
            ticks(130);
            chk("period", period_len, (16 + 4 * f[1:0]) * (f[2] ? 2 : 1) * TPC);
            chk("high", high_len, ((f[1] ? 12 : 8) - f) * (f[2] ? 2 : 1) * TPC);
        end
        rd("ctl_on", BTG_CTL_ADDR, 32'h01);
        wr(BTG_CTL_ADDR, 32'h0D);
        ticks(100);
        rd("ctl_mode3", BTG_CTL_ADDR, 32'h0D);
        wr(BTG_CTL_ADDR, 32'h00);
        ticks(3);
        chk("tone_off", {31'h0, tone_out}, 32'h0);
        // One-shot length for each time code
        for (int t = 0; t < 4; t++) begin
            wr(BTG_CTL_ADDR, t * 16 + 5);
            t0 = tk;
            ticks(2);
            rd("os_busy", BTG_CTL_ADDR, t * 16 + 5);
            run_len(t0, int'(us_tab[t] * SND_HZ / BTG_US_PER_S), "os_len");
        end
        wr(BTG_CTL_ADDR, 32'h05);
        ticks(32);
        wr(BTG_CTL_ADDR, 32'h05);
        run_len(tk, 64, "os_restart");
        wr(BTG_CTL_ADDR, 32'h15);
        ticks(10);
        wr(BTG_CTL_ADDR, 32'h14);
        ticks(2);
        rd("os_stop", BTG_CTL_ADDR, 32'h14);
        chk("os_stop_tone", {31'h0, tone_out}, 32'h0);
        // Envelope with the programmed duty at minimum, which must be ignored
        wr(BTG_DUTY_ADDR, 32'h07);
        wr(BTG_FREQ_ADDR, 32'h00);
        wr(BTG_CTL_ADDR, 32'h09);
        ticks(40);
        chk("env_lvl1", high_len, 8 * TPC);
        ticks(130);
        chk("env_lvl3", high_len, 6 * TPC);
        wr(BTG_CTL_ADDR, 32'h09);
        t0 = tk;
        ticks(40);
        chk("env_restart", high_len, 8 * TPC);
        run_len(t0, 7 * 64, "env_len");
        tally_and_finish();
    end
endmodule
